// >>> pew_host.sv
// host controller for a parallel eeprom with page write and soft guard
// assumes a simple user request port and the device pins on the far side
// Overview of operation
// - write starts by strobe low, drive high
// - page holds one to sixty-four bytes
// - next byte within 150 us
// - page select bits fixed within page
// - guard enabled by three writes, wait
// - guarded writes need command prefix
// - commands obey page load timing
// - id qualifier opens 64-byte id area
`timescale 1ns/1ps
module pew_host
  import pew_pkg::*;
#(
  parameter int unsigned WCT_CYC = PEW_WCT_CYC, // write_cycle_time polling limit
  parameter int unsigned BLW_CYC = PEW_BLW_CYC  // byte_load_window in cycles
)(
  input  wire logic        sys_clk,              // 40 MHz clock
  input  wire logic        sys_rst,              // synchronous reset
  input  wire logic        req_valid,            // user request present
  input  wire pew_op_e     req_op,               // request kind
  input  wire logic [12:0] req_addr,             // byte address
  input  wire logic [7:0]  req_data,             // write byte
  input  wire logic        req_last,             // last byte of page
  input  wire logic        req_guarded,          // prefix write with guard command
  input  wire logic        req_id,               // target the id area
  output logic             req_ready,            // request taken this cycle
  output logic             rsp_valid,            // read data or write done pulse
  output logic      [7:0]  rsp_data,             // read byte
  output logic             rsp_timeout,          // write polling timed out
  input  wire logic [7:0]  dq_in,                // data pins in
  output logic      [7:0]  dq_out,               // data pins out
  output logic             dq_oe,                // data pins drive enable
  output logic      [12:0] mem_addr,             // address pins
  output logic             chip_en_n,            // chip enable
  output logic             out_drv_n,            // output drive
  output logic             wr_strobe_n,          // write strobe
  output logic             id_area_qualifier_line // id voltage qualifier
);
  typedef enum {S_IDLE, S_PFX0, S_PFX1, S_PFX2, S_CYC, S_LOAD, S_POLL} pew_state_e;
  pew_state_e  state;            // sequencer state
  pew_strobe_if cyc ();          // engine link
  logic [2:0]  pfx_idx;          // command prefix step
  logic [7:0]  last_byte;        // last byte written for polling
  logic [12:0] last_addr;        // its address
  logic [12:0] page_addr;        // page select bits of current load
  logic [31:0] tmr;              // window or polling timer
  logic        poll_wait;        // awaiting a poll read
  logic [7:0]  prev_rd;          // previous poll read
  logic        have_prev;        // prev_rd valid
  logic [7:0]  pfx_last;         // third command byte
  logic [12:0] req_pin_addr;     // request address as put on the pins
  logic [31:0] load_gap;         // cycles since the last strobe rise
  // first window count that can no longer start a load; the strobe rise comes 5 cycles after a start
  localparam int unsigned LOAD_LIMIT = BLW_CYC - 3 * PEW_STROBE_CYC;

  pew_pin_engine u_eng (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .cyc         (cyc),
    .dq_in       (dq_in),
    .mem_addr    (mem_addr),
    .dq_out      (dq_out),
    .dq_oe       (dq_oe),
    .chip_en_n   (chip_en_n),
    .out_drv_n   (out_drv_n),
    .wr_strobe_n (wr_strobe_n)
  );

  // command address for a prefix step
  function automatic logic [12:0] pfx_addr(input logic [2:0] i);
    pfx_addr = (i == 3'd0) ? PEW_CMD_ADDR0 : (i == 3'd1) ? PEW_CMD_ADDR1 : PEW_CMD_ADDR2;
  endfunction

  // command data for a prefix step
  function automatic logic [7:0] pfx_data(input logic [2:0] i, input logic [7:0] last);
    pfx_data = (i == 3'd0) ? PEW_CMD_DATA0 : (i == 3'd1) ? PEW_CMD_DATA1 : last;
  endfunction

  // id requests map onto the id area; page bits are compared in pin terms
  assign req_pin_addr = req_id ? (PEW_ID_BASE | {7'h00, req_addr[5:0]}) : req_addr;

  // cycles since the last write strobe rise, for the byte window check
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      load_gap <= 32'd0;
    end else if ($rose(wr_strobe_n)) begin
      load_gap <= 32'd0;
    end else begin
      load_gap <= load_gap + 32'd1;
    end
  end

  // main sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= S_IDLE; pfx_idx <= 3'd0; req_ready <= 1'b0; rsp_valid <= 1'b0;
      rsp_data <= 8'h00; rsp_timeout <= 1'b0; id_area_qualifier_line <= 1'b0;
      cyc.go <= 1'b0; cyc.wr <= 1'b0; cyc.addr <= 13'h0000; cyc.wdata <= 8'h00;
      last_byte <= 8'h00; last_addr <= 13'h0000; page_addr <= 13'h0000;
      tmr <= 32'd0; poll_wait <= 1'b0; prev_rd <= 8'h00; have_prev <= 1'b0; pfx_last <= 8'h00;
    end else begin
      req_ready <= 1'b0; rsp_valid <= 1'b0; cyc.go <= 1'b0;
      unique case (state)
        // take a new request
        S_IDLE: begin
          rsp_timeout <= 1'b0;
          if (req_valid && !req_ready) begin
            id_area_qualifier_line <= req_id;
            cyc.addr <= req_pin_addr;
            cyc.wdata <= req_data; pfx_idx <= 3'd0;
            if (req_op == PEW_OP_READ) begin
              cyc.wr <= 1'b0; cyc.go <= 1'b1; req_ready <= 1'b1; state <= S_CYC;
            end else if (req_op == PEW_OP_WRITE && !req_guarded) begin
              cyc.wr <= 1'b1; cyc.go <= 1'b1; req_ready <= 1'b1; state <= S_CYC;
            end else begin
              pfx_last <= (req_op == PEW_OP_GUARD_OFF) ? PEW_CMD_DIS : PEW_CMD_EN;
              state <= S_PFX0;
            end
          end
        end
        // issue a command prefix write
        S_PFX0: begin
          cyc.wr <= 1'b1; cyc.go <= 1'b1; state <= S_PFX1;
          cyc.addr <= pfx_addr(pfx_idx); cyc.wdata <= pfx_data(pfx_idx, pfx_last);
        end
        // wait for prefix write; back to back keeps load timing
        S_PFX1: if (cyc.done) begin
          pfx_idx <= pfx_idx + 3'd1;
          state <= (pfx_idx == 3'd2) ? S_PFX2 : S_PFX0;
        end
        // after three command writes: data follows, or a bare command polls out
        S_PFX2: begin
          if (req_op == PEW_OP_WRITE) begin
            cyc.addr <= req_pin_addr;
            cyc.wdata <= req_data; cyc.wr <= 1'b1; cyc.go <= 1'b1;
            req_ready <= 1'b1; state <= S_CYC;
          end else begin
            req_ready <= 1'b1; last_addr <= PEW_CMD_ADDR2; last_byte <= pfx_last;
            tmr <= 32'd0; have_prev <= 1'b0; poll_wait <= 1'b0; state <= S_POLL;
          end
        end
        // a pin cycle is running
        S_CYC: if (cyc.done) begin
          if (!cyc.wr) begin
            rsp_data <= cyc.rdata; rsp_valid <= 1'b1; state <= S_IDLE;
            id_area_qualifier_line <= 1'b0;
          end else begin
            last_addr <= cyc.addr; last_byte <= cyc.wdata; page_addr <= cyc.addr; tmr <= 32'd0;
            state <= req_last ? S_POLL : S_LOAD;
            have_prev <= 1'b0; poll_wait <= 1'b0;
          end
        end
        // page load: next byte of same page within the window
        S_LOAD: begin
          tmr <= tmr + 32'd1;
          if (req_valid && req_op == PEW_OP_WRITE && !req_ready && req_id == id_area_qualifier_line &&
              req_pin_addr[12:6] == page_addr[12:6] && tmr < 32'(LOAD_LIMIT)) begin
            cyc.addr <= req_pin_addr;
            cyc.wdata <= req_data; cyc.wr <= 1'b1; cyc.go <= 1'b1;
            req_ready <= 1'b1; state <= S_CYC;
          end else if (tmr >= 32'(LOAD_LIMIT)) begin
            tmr <= 32'd0; state <= S_POLL;
          end
        end
        // poll last byte until line 7 true and line 6 stops toggling
        S_POLL: begin
          tmr <= tmr + 32'd1;
          if (!poll_wait) begin
            cyc.addr <= last_addr; cyc.wr <= 1'b0; cyc.go <= 1'b1; poll_wait <= 1'b1;
          end else if (cyc.done) begin
            poll_wait <= 1'b0; prev_rd <= cyc.rdata; have_prev <= 1'b1;
            if (cyc.rdata[7] == last_byte[7] && have_prev &&
                cyc.rdata[6] == prev_rd[6]) begin
              rsp_valid <= 1'b1; id_area_qualifier_line <= 1'b0; state <= S_IDLE;
            end else if (tmr >= 32'(WCT_CYC)) begin
              rsp_valid <= 1'b1; rsp_timeout <= 1'b1; id_area_qualifier_line <= 1'b0; state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // polling ends: back to idle with the done pulse
  sequence s_poll_done;
    state == S_POLL ##1 (state == S_IDLE && rsp_valid);
  endsequence

  // a further page byte is launched from the load state
  sequence s_load_go;
    state == S_LOAD ##1 (state == S_CYC && cyc.go);
  endsequence

  // polling stops within 40 cycles past its limit
  property p_poll_bounded;
    @(posedge sys_clk) disable iff (sys_rst) (state == S_POLL && !rsp_timeout && tmr > 32'(WCT_CYC) + 32'd40)
      |-> 1'b0;
  endproperty
  a_poll_bounded: assert property (p_poll_bounded) else $error("polling ran past limit");

  // page bits held within one load
  property p_page_same;
    @(posedge sys_clk) disable iff (sys_rst) s_load_go |-> cyc.addr[12:6] == page_addr[12:6];
  endproperty
  a_page_same: assert property (p_page_same) else $error("page changed mid load");

  // next byte is latched within the window of the previous one; its strobe rises 6 cycles on
  property p_window;
    @(posedge sys_clk) disable iff (sys_rst) s_load_go |-> load_gap + 32'd6 <= 32'(BLW_CYC);
  endproperty
  a_window: assert property (p_window) else $error("byte window exceeded");

  // done pulse after polling lasts one cycle
  property p_rsp_pulse;
    @(posedge sys_clk) disable iff (sys_rst) s_poll_done |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response not a pulse");
endmodule

// >>> pew_pkg.sv
// package for the parallel eeprom page-write host controller
// assumes a 40 MHz system clock; all timing is counted in sys_clk cycles
package pew_pkg;
  localparam int unsigned PEW_CLK_MHZ        = 40;             // system clock rate
  localparam int unsigned PEW_ADDR_W         = 13;             // address width
  localparam int unsigned PEW_DATA_W         = 8;              // data width
  localparam int unsigned PEW_PAGE_BYTES     = 64;             // bytes in one page
  localparam int unsigned PEW_BYTE_BITS      = 6;              // byte_in_page_bits width
  localparam int unsigned PEW_STROBE_NS      = 75;             // least strobe low time, well above 15 ns filter
  localparam int unsigned PEW_STROBE_CYC     = (PEW_STROBE_NS * PEW_CLK_MHZ + 999) / 1000;
  localparam int unsigned PEW_BLW_US         = 150;            // byte_load_window
  localparam int unsigned PEW_BLW_CYC        = PEW_BLW_US * PEW_CLK_MHZ;
  localparam int unsigned PEW_WCT_US         = 10000;          // write_cycle_time upper bound
  localparam int unsigned PEW_WCT_CYC        = PEW_WCT_US * PEW_CLK_MHZ;
  localparam int unsigned PEW_SETTLE_CYC     = 4;              // pin sync depth plus read access margin
  localparam logic [12:0] PEW_ID_BASE        = 13'h1FC0;       // first address of id area
  localparam logic [12:0] PEW_CMD_ADDR0      = 13'h1555;       // guard command address 0, neutral default
  localparam logic [12:0] PEW_CMD_ADDR1      = 13'h0AAA;       // guard command address 1, neutral default
  localparam logic [12:0] PEW_CMD_ADDR2      = 13'h1555;       // guard command address 2, neutral default
  localparam logic [7:0]  PEW_CMD_DATA0      = 8'hAA;          // guard command byte 0, neutral default
  localparam logic [7:0]  PEW_CMD_DATA1      = 8'h55;          // guard command byte 1, neutral default
  localparam logic [7:0]  PEW_CMD_EN         = 8'hA0;          // guard enable byte 2, neutral default
  localparam logic [7:0]  PEW_CMD_DIS        = 8'h20;          // guard disable byte 2, neutral default
  typedef enum logic [1:0] {PEW_OP_READ, PEW_OP_WRITE, PEW_OP_GUARD_ON, PEW_OP_GUARD_OFF} pew_op_e;
endpackage

// >>> pew_strobe_if.sv
// interface between the sequencer and the pin-cycle engine
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface pew_strobe_if;
  logic        go;     // start one pin cycle
  logic        wr;     // 1 write cycle, 0 read cycle
  logic [12:0] addr;   // address for this cycle
  logic [7:0]  wdata;  // data for a write cycle
  logic        done;   // pulse: cycle finished
  logic [7:0]  rdata;  // byte sampled on a read cycle
  modport seq (output go, wr, addr, wdata, input done, rdata);
  modport eng (input go, wr, addr, wdata, output done, rdata);
endinterface

// >>> pew_pin_engine.sv
// pin-cycle engine: drives one we-controlled write or oe-controlled read
// assumes data pins return through three flops before sampling
`timescale 1ns/1ps
module pew_pin_engine
  import pew_pkg::*;
(
  input  wire logic        sys_clk,     // 40 MHz clock
  input  wire logic        sys_rst,     // synchronous reset
  pew_strobe_if.eng        cyc,         // cycle request
  input  wire logic [7:0]  dq_in,       // data pins as seen
  output logic      [12:0] mem_addr,    // address pins
  output logic      [7:0]  dq_out,      // data pin drive value
  output logic             dq_oe,       // data pin drive enable
  output logic             chip_en_n,   // chip enable, low active
  output logic             out_drv_n,   // output drive, low active
  output logic             wr_strobe_n  // write strobe, low active
);
  logic [7:0] sync1, sync2, sync3; // data pin synchroniser
  logic [7:0] cnt;                 // phase counter
  logic       busy;                // cycle running

  // three-flop data synchroniser
  always_ff @(posedge sys_clk) begin
    sync1 <= dq_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // pin sequencing; address set before strobe, data held past rising edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0; cnt <= 8'h00; cyc.done <= 1'b0; cyc.rdata <= 8'h00;
      mem_addr <= 13'h0000; dq_out <= 8'h00; dq_oe <= 1'b0;
      chip_en_n <= 1'b1; out_drv_n <= 1'b1; wr_strobe_n <= 1'b1;
    end else begin
      cyc.done <= 1'b0;
      if (!busy) begin
        if (cyc.go) begin
          busy <= 1'b1; cnt <= 8'h00;
          mem_addr <= cyc.addr; dq_out <= cyc.wdata;
          dq_oe <= cyc.wr; chip_en_n <= 1'b0;
          out_drv_n <= 1'b1;
        end
      end else begin
        cnt <= cnt + 8'h01;
        if (cyc.wr) begin
          // address latched on late falling edge, data on first rising edge
          if (cnt == 8'h00) wr_strobe_n <= 1'b0;
          if (cnt == 8'(PEW_STROBE_CYC)) wr_strobe_n <= 1'b1;
          if (cnt == 8'(PEW_STROBE_CYC + 1)) begin
            chip_en_n <= 1'b1; dq_oe <= 1'b0; busy <= 1'b0; cyc.done <= 1'b1;
          end
        end else begin
          if (cnt == 8'h00) out_drv_n <= 1'b0;
          if (cnt == 8'(PEW_STROBE_CYC + PEW_SETTLE_CYC)) begin
            cyc.rdata <= sync3; out_drv_n <= 1'b1; chip_en_n <= 1'b1;
            busy <= 1'b0; cyc.done <= 1'b1;
          end
        end
      end
    end
  end

  // write strobe never falls while output drive is low
  property p_no_wr_with_oe;
    @(posedge sys_clk) disable iff (sys_rst) $fell(wr_strobe_n) |-> out_drv_n && !chip_en_n;
  endproperty
  a_no_wr_with_oe: assert property (p_no_wr_with_oe) else $error("write strobe with output drive low");

  // strobe low long enough to pass the noise filter
  property p_strobe_width;
    @(posedge sys_clk) disable iff (sys_rst) $fell(wr_strobe_n) |-> !wr_strobe_n [*3];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short");

  // data driven and stable across the strobe rise and one cycle past it
  property p_data_hold;
    @(posedge sys_clk) disable iff (sys_rst) $rose(wr_strobe_n) |-> dq_oe && $stable(dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");

  // no bus contention: host drives only while device outputs are off
  property p_no_contend;
    @(posedge sys_clk) disable iff (sys_rst) dq_oe |-> out_drv_n;
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("host drives while output drive low");
endmodule

// >>> pew_eeprom_model.sv
// behavioural eeprom on the host pins: array, page latches, soft guard
// assumes no host clock; its own time base runs both timers
`timescale 1ns/1ps
module pew_eeprom_model
  import pew_pkg::*;
#(
  parameter int unsigned WIN_TICKS = 50,  // byte_load_window in ticks
  parameter int unsigned WCT_TICKS = 200  // write_cycle_time in ticks
)(
  input  wire logic        chip_en_n,   // chip enable
  input  wire logic        out_drv_n,   // output drive
  input  wire logic        wr_strobe_n, // write strobe
  input  wire logic [12:0] mem_addr,    // address pins
  input  wire logic [7:0]  dq,          // resolved data lines
  input  wire logic        id_q,        // id_area_qualifier_line
  output logic      [7:0]  dq_drv,      // byte put out
  output logic             dq_en,       // device drives lines
  output int               bad          // strobe and page-select misuse count
);
  logic [7:0]  mem [0:8191];             // main array
  logic [7:0]  idm [0:63];               // id area
  logic [7:0]  pb [0:63];                // page latches
  logic [63:0] pv = '0;                  // latch loaded flags
  logic [12:0] la;                       // latched address
  logic [6:0]  pg;                       // page of this load
  logic [1:0]  cs = 0;                   // command step
  logic [7:0]  ld = 0;                   // last byte loaded
  logic [7:0]  pend = 0;                 // pending guard command
  logic        on = 0, lod = 0, busy = 0, unlk = 0, tog = 0, tk = 0, pgs = 0, pid = 0;
  logic        guard = 0;                // off as delivered
  int          win = 0, wct = 0;         // timer counts
  realtime     tf;                       // time of the write start
  initial bad = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  initial foreach (idm[i]) idm[i] = 8'hFF;
  // free-running time base, unrelated to the host clock
  always #9.7 tk = ~tk;
  // address latches on the later falling strobe
  always @(negedge wr_strobe_n or negedge chip_en_n) begin
    if (!wr_strobe_n && !chip_en_n) begin
      if (!out_drv_n) bad++;
      else begin
        la = mem_addr;
        on = 1;
        tf = $realtime;
      end
    end
  end
  // data latches on the first rising strobe; short pulses are misuse
  always @(posedge wr_strobe_n or posedge chip_en_n) begin
    if (on) begin
      on = 0;
      if ($realtime - tf < 15.0) bad++;
      else if (!busy) load_byte(la, dq);
    end
  end
  // one byte load: command steps, page check, latch
  task automatic load_byte(input logic [12:0] a, input logic [7:0] d);
    win = 0;
    lod = 1;
    ld = d;
    if (cs == 0 && a == PEW_CMD_ADDR0 && d == PEW_CMD_DATA0) cs = 1;
    else if (cs == 1 && a == PEW_CMD_ADDR1 && d == PEW_CMD_DATA1) cs = 2;
    else if (cs == 2 && a == PEW_CMD_ADDR2 && (d == PEW_CMD_EN || d == PEW_CMD_DIS)) begin
      cs = 0;
      pend = d;
      unlk = 1;
    end else begin
      cs = 0;
      if (pgs && a[12:6] != pg) bad++;
      pg = a[12:6];
      pgs = 1;
      pid = id_q && a >= PEW_ID_BASE;
      if (!guard || unlk) begin
        pb[a[5:0]] = d;
        pv[a[5:0]] = 1;
      end
    end
  endtask
  // window expiry starts programming; programming commits latched bytes
  always @(posedge tk) begin
    if (busy) begin
      wct++;
      if (wct >= WCT_TICKS) begin
        for (int i = 0; i < 64; i++) begin
          if (pv[i] && pid) idm[i] = pb[i];
          else if (pv[i]) mem[{pg, i[5:0]}] = pb[i];
        end
        if (pend == PEW_CMD_EN) guard = 1;
        if (pend == PEW_CMD_DIS) guard = 0;
        busy = 0;
        pv = '0;
        pend = 0;
        unlk = 0;
        pgs = 0;
      end
    end else if (lod) begin
      win++;
      if (win >= WIN_TICKS) begin
        lod = 0;
        busy = 1;
        wct = 0;
      end
    end
  end
  // toggle status flips on each read while not ready
  always @(negedge out_drv_n) if (!chip_en_n && (busy || lod)) tog = ~tog;
  assign dq_en = !chip_en_n && !out_drv_n && wr_strobe_n;
  assign dq_drv = (busy || lod) ? {~ld[7], tog, ld[5:0]} :
                  (id_q && mem_addr >= PEW_ID_BASE) ? idm[mem_addr[5:0]] : mem[mem_addr];
endmodule

// >>> pew_host_bench.sv
// self-checking bench for the eeprom host controller
// assumes the behavioural eeprom model sits on the device pins
`timescale 1ns/1ps
module pew_host_bench
  import pew_pkg::*;
;
  logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_last = 0, req_guarded = 0, req_id = 0;
  pew_op_e     req_op = PEW_OP_READ;           // request kind
  logic [12:0] req_addr = 0, mem_addr;         // addresses
  logic [7:0]  req_data = 0, rsp_data, dq_out; // data
  logic req_ready, rsp_valid, rsp_timeout, dq_oe, chip_en_n, out_drv_n, wr_strobe_n, id_area_qualifier_line;
  logic [7:0]  bus, last_bus = 0, dev_d;       // resolved lines
  logic        dev_en;                         // device drives lines
  int          bad_cnt, errors = 0, checked = 0;
  logic [7:0]  exp_mem [0:8191];               // expected array
  logic [7:0]  exp_id [0:63];                  // expected id area
  logic [15:0] seed = 16'h2785;                // starts at 10117
  always #12.5 sys_clk = ~sys_clk;
  // released lines show the inverse of their last level
  assign bus = dq_oe ? dq_out : (dev_en ? dev_d : ~last_bus);
  pew_host #(.WCT_CYC(400), .BLW_CYC(60)) u_dut (
    .sys_clk, .sys_rst, .req_valid, .req_op, .req_addr, .req_data, .req_last, .req_guarded, .req_id,
    .req_ready, .rsp_valid, .rsp_data, .rsp_timeout, .dq_in(bus), .dq_out, .dq_oe, .mem_addr,
    .chip_en_n, .out_drv_n, .wr_strobe_n, .id_area_qualifier_line);
  pew_eeprom_model #(.WIN_TICKS(80), .WCT_TICKS(200)) u_mem (
    .chip_en_n, .out_drv_n, .wr_strobe_n, .mem_addr, .dq(bus), .id_q(id_area_qualifier_line),
    .dq_drv(dev_d), .dq_en(dev_en), .bad(bad_cnt));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hold the request until ready is seen at an edge, then drop it
  task automatic req(input pew_op_e op, input logic [12:0] a, input logic [7:0] d, input logic l, g, id);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_last <= l;
    req_guarded <= g;
    req_id <= id;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 0;
    if (n >= 3000) cmp1(1, 0);
  endtask
  task automatic wait_rsp;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    if (n >= 3000) cmp1(1, 0);
  endtask
  task automatic done_wr;
    wait_rsp;
    cmp1(rsp_timeout, 0);
  endtask
  task automatic rd(input logic [12:0] a, input logic id);
    req(PEW_OP_READ, a, 8'h00, 0, 0, id);
    wait_rsp;
    cmp8(rsp_data, id ? exp_id[a[5:0]] : exp_mem[a]);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l, g, id, st);
    req(PEW_OP_WRITE, a, d, l, g, id);
    if (st && id) exp_id[a[5:0]] = d;
    else if (st) exp_mem[a] = d;
    if (l) done_wr;
  endtask
  task automatic pulse_reset;
    @(posedge sys_clk);
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
  endtask
  // bus contention would mean a write with the device driving
  always @(posedge sys_clk) begin
    last_bus <= bus;
    if (dq_oe && dev_en) cmp1(1, 0);
  end
  initial begin
    #1000000;
    errors++;
    finish_test;
  end
  initial begin
    logic [12:0] a;
    logic [7:0]  d;
    logic [5:0]  k;
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    foreach (exp_id[i]) exp_id[i] = 8'hFF;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmp1(chip_en_n & out_drv_n & wr_strobe_n, 1);
    cmp1(dq_oe, 0);
    @(posedge sys_clk);
    sys_rst <= 0;
    rd(13'h0040, 0);
    // random single bytes, each read straight back
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = seed[12:0];
      seed = lfsr(seed);
      wr(a, seed[7:0], 1, 0, 0, 1);
      rd(a, 0);
    end
    // full page in scrambled order with one byte overwritten
    seed = lfsr(seed);
    a = {seed[6:0], 6'h00};
    k = seed[13:8];
    wr(a | k, 8'h5A, 0, 0, 0, 1);
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      wr(a | (i[5:0] ^ k), seed[7:0], i == 63, 0, 0, 1);
    end
    for (int i = 0; i < 64; i += 9) rd(a | i[5:0], 0);
    // short page ended by the window running out
    a = {~a[12:6], 6'h00};
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(a | 6'(i * 5), seed[7:0], 0, 0, 0, 1);
    end
    done_wr;
    rd(a | 6'd5, 0);
    rd(a | 6'd1, 0);
    // soft guard on, plain write blocked, prefixed write passes
    req(PEW_OP_GUARD_ON, 13'h0000, 8'h00, 0, 0, 0);
    done_wr;
    rd(PEW_CMD_ADDR1, 0);
    seed = lfsr(seed);
    a = seed[12:0];
    d = {exp_mem[a][7], seed[14:8]};
    wr(a, d, 1, 0, 0, 0);
    rd(a, 0);
    wr(a, ~d, 1, 1, 0, 1);
    rd(a, 0);
    wr(PEW_CMD_ADDR2, 8'h3C, 1, 1, 0, 1);
    rd(PEW_CMD_ADDR2, 0);
    pulse_reset;
    d = {exp_mem[a][7], d[6:0]};
    wr(a, d, 1, 0, 0, 0);
    rd(a, 0);
    req(PEW_OP_GUARD_OFF, 13'h0000, 8'h00, 0, 0, 0);
    done_wr;
    wr(a, d, 1, 0, 0, 1);
    rd(a, 0);
    // id area beside the main array
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      a = PEW_ID_BASE | 13'(seed[13:8]);
      wr(a, seed[7:0], 1, 0, 1, 1);
      rd(a, 1);
      rd(a, 0);
    end
    cmp1(bad_cnt == 0, 1);
    finish_test;
  end
endmodule
